// ===== rtl/spfcm_pkg.sv
// Shared constants and types for the servo parameter fetch and cycle monitor
package spfcm_pkg;

  // Timing, each figure in its own unit
  localparam int CLK_PERIOD_NS  = 20;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int WDT_TIME_MS    = 1600;
  localparam int SEC_TIME_MS    = 1000;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // Sizes
  localparam int AXES_LARGE  = 32;
  localparam int AXES_SMALL  = 8;
  localparam int AXIS_IDX_W  = 5;
  localparam int PARAM_IDX_W = 6;
  localparam int PARAM_W     = 16;
  localparam int CYCLE_W     = 16;
  localparam int RAM_AW      = AXIS_IDX_W + PARAM_IDX_W;

  localparam logic [CYCLE_W-1:0] CYCLE_MAX = 16'hFFFF;
  localparam logic [CYCLE_W-1:0] WDT_LIMIT = CYCLE_W'(WDT_TIME_MS);
  localparam logic [9:0]         SEC_LAST  = 10'(SEC_TIME_MS - 1);

  // Register byte offsets
  localparam logic [7:0] REG_CUR_CYCLE  = 8'h00;
  localparam logic [7:0] REG_PEAK_CYCLE = 8'h04;
  localparam logic [7:0] REG_CTRL       = 8'h08;
  localparam logic [7:0] REG_FETCH_AXIS = 8'h0C;
  localparam logic [7:0] REG_AXIS_USED  = 8'h10;
  localparam logic [7:0] REG_PARAM_SEL  = 8'h14;
  localparam logic [7:0] REG_PARAM_DATA = 8'h18;
  localparam logic [7:0] REG_CLOCK_DATA = 8'h1C;
  localparam logic [7:0] REG_ERR_CODE   = 8'h20;
  localparam logic [7:0] REG_ERR_STAMP  = 8'h24;

  // Control register bits
  localparam int CTRL_REQ_BIT    = 0;
  localparam int CTRL_ACTIVE_BIT = 1;
  localparam int CTRL_WDT_BIT    = 2;
  localparam int CTRL_ERR_BIT    = 3;
  localparam int CTRL_CLKREQ_BIT = 4;

  typedef enum logic [1:0] {
    FS_IDLE  = 2'h0,
    FS_START = 2'h1,
    FS_XFER  = 2'h3,
    FS_DONE  = 2'h2
  } spfcm_fsm_type;

  typedef struct packed {
    logic                  changed;
    logic [AXIS_IDX_W-1:0] changed_idx;
    logic                  valid;
    logic                  last;
    logic [PARAM_W-1:0]    data;
  } spfcm_amp_in_type;

  typedef struct packed {
    logic                  start;
    logic [AXIS_IDX_W-1:0] axis_idx;
    logic                  active;
  } spfcm_amp_out_type;

  typedef struct packed {
    logic [15:0]            ms_cnt;
    logic [CYCLE_W-1:0]     elapsed;
    logic [CYCLE_W-1:0]     cur;
    logic [CYCLE_W-1:0]     peak;
    logic                   wdt;
    logic [2:0]             mark_s;
    logic                   mark_lvl;
    logic [31:0]            pwr1;
    logic [31:0]            pwr2;
    logic [31:0]            pwr3;
    logic [31:0]            pwr_lvl;
    logic                   ack;
    logic [31:0]            rdata;
    logic                   req;
    logic                   req_prev;
    logic [15:0]            axis;
    logic [31:0]            used;
    spfcm_fsm_type          fsm;
    logic [AXIS_IDX_W-1:0]  fetch_axis;
    logic [PARAM_IDX_W-1:0] idx;
    logic                   auto_pend;
    logic [AXIS_IDX_W-1:0]  auto_axis;
    logic [RAM_AW-1:0]      sel;
    logic [31:0]            clk_data;
    logic                   clk_req;
    logic                   clk_req_prev;
    logic [31:0]            rtc;
    logic [9:0]             sec_ms;
    logic                   err_flag;
    logic [15:0]            err_code;
    logic [31:0]            err_stamp;
  } spfcm_state_type;

endpackage : spfcm_pkg

// ===== rtl/spfcm_param_ram.sv
// Servo parameter storage, one write port and a registered read port
`timescale 1ns/100ps
`default_nettype none
module spfcm_param_ram #(
  parameter int DW = 16,
  parameter int AW = 11
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output var  logic [DW-1:0] rdata
);

  // No reset: contents are undefined until a fetch fills them
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : spfcm_param_ram
`default_nettype wire

// ===== rtl/spfcm_top.sv
// Main cycle monitor and servo parameter fetch register bank
// Operation
// - Current cycle time kept in milliseconds
// - Longest cycle time kept separately
// - Watchdog error when cycle exceeds 1.6 s
// - Requested fetch starts only on request rising edge
// - Request ignored while fetch is active
// - Hardware never clears the request flag
// - Active flag high during transfer, auto-cleared
// - Skip unused or unpowered axis
// - Out-of-range axis number does nothing
// - Valid request copies parameters into storage
// - Spontaneous parameter changes fetched automatically
// - Auto update may be lost on reset
// - Runtime errors recorded with code and flag
// - Error stamped from settable internal clock
`timescale 1ns/100ps
`default_nettype none
module spfcm_top #(
  parameter int unsigned TICK_CYCLES = spfcm_pkg::TICK_CYCLES,
  parameter bit          LARGE_VARIANT = 1'b1
) (
  input  wire logic                       REF_CLK,
  input  wire logic                       SYS_RST,
  input  wire logic                       WB_CYC_I,
  input  wire logic                       WB_STB_I,
  input  wire logic                       WB_WE_I,
  input  wire logic [7:0]                 WB_ADR_I,
  input  wire logic [3:0]                 WB_SEL_I,
  input  wire logic [31:0]                WB_DAT_I,
  output var  logic [31:0]                WB_DAT_O,
  output var  logic                       WB_ACK_O,
  input  wire logic                       MAIN_CYCLE_MARK,
  input  wire logic [31:0]                AXIS_POWERED,
  input  wire spfcm_pkg::spfcm_amp_in_type  AMP_IN,
  output var  spfcm_pkg::spfcm_amp_out_type AMP_OUT,
  input  wire logic                       ERROR_EVENT,
  input  wire logic [15:0]                ERROR_CODE,
  output var  logic                       WDT_ERROR
);

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
  localparam logic [15:0] MAX_AXES  = LARGE_VARIANT ?
                                      16'(spfcm_pkg::AXES_LARGE) :
                                      16'(spfcm_pkg::AXES_SMALL);

  spfcm_pkg::spfcm_state_type r;
  spfcm_pkg::spfcm_state_type n;

  logic                                 bus_req;
  logic                                 wr_en;
  logic [7:0]                           adr;
  logic                                 tick;
  logic                                 mark_rise;
  logic                                 req_rise;
  logic                                 axis_ok;
  logic [spfcm_pkg::AXIS_IDX_W-1:0]     axis_idx;
  logic                                 mem_we;
  logic [spfcm_pkg::RAM_AW-1:0]         mem_waddr;
  logic [spfcm_pkg::PARAM_W-1:0]        mem_rdata;
  logic [31:0]                          wv;

  // Merge write data into an old value, lane by lane
  function automatic logic [31:0] spfcm_lanes(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (be[i])
        res[8*i +: 8] = new_v[8*i +: 8];
    return res;
  endfunction : spfcm_lanes

  spfcm_param_ram #(
    .DW (spfcm_pkg::PARAM_W),
    .AW (spfcm_pkg::RAM_AW)
  ) u_ram (
    .clk   (REF_CLK),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (AMP_IN.data),
    .raddr (r.sel),
    .rdata (mem_rdata)
  );

  always_comb
  begin
    n         = r;
    bus_req   = WB_CYC_I & WB_STB_I;
    wr_en     = bus_req & WB_WE_I & r.ack;
    adr       = {WB_ADR_I[7:2], 2'h0};
    wv        = 32'h0;
    mem_we    = 1'b0;
    mem_waddr = {r.fetch_axis, r.idx};

    // Input synchronisers; a level counts once stages two and three agree
    n.mark_s   = {r.mark_s[1:0], MAIN_CYCLE_MARK};
    n.mark_lvl = (r.mark_s[1] & r.mark_s[2]) |
                 (r.mark_lvl & (r.mark_s[1] | r.mark_s[2]));
    mark_rise  = n.mark_lvl & ~r.mark_lvl;
    n.pwr1     = AXIS_POWERED;
    n.pwr2     = r.pwr1;
    n.pwr3     = r.pwr2;
    n.pwr_lvl  = (r.pwr2 & r.pwr3) | (r.pwr_lvl & (r.pwr2 | r.pwr3));

    // Millisecond time base
    tick     = (r.ms_cnt == TICK_LAST);
    n.ms_cnt = tick ? 16'h0 : r.ms_cnt + 16'h1;

    // Cycle timing; elapsed saturates rather than wrapping
    if (mark_rise)
    begin
      n.cur     = r.elapsed;
      n.elapsed = 16'h0;
      n.ms_cnt  = 16'h0;
      if (r.elapsed > r.peak)
        n.peak = r.elapsed;
    end
    else if (tick && r.elapsed != spfcm_pkg::CYCLE_MAX)
      n.elapsed = r.elapsed + 16'h1;
    if (r.elapsed > spfcm_pkg::WDT_LIMIT)
      n.wdt = 1'b1;

    // Internal clock for error stamps, in seconds
    if (tick)
    begin
      n.sec_ms = (r.sec_ms == spfcm_pkg::SEC_LAST) ?
                 10'h0 : r.sec_ms + 10'h1;
      if (r.sec_ms == spfcm_pkg::SEC_LAST)
        n.rtc = r.rtc + 32'h1;
    end
    n.clk_req_prev = r.clk_req;
    if (r.clk_req && !r.clk_req_prev)
    begin
      n.rtc    = r.clk_data;
      n.sec_ms = 10'h0;
    end

    // Bus slave: ack one cycle after the request, write on the acked edge
    n.ack = bus_req & ~r.ack;
    if (bus_req && !r.ack)
    begin
      case (adr)
        spfcm_pkg::REG_CUR_CYCLE:  n.rdata = {16'h0, r.cur};
        spfcm_pkg::REG_PEAK_CYCLE: n.rdata = {16'h0, r.peak};
        spfcm_pkg::REG_CTRL:
        begin
          n.rdata = 32'h0;
          n.rdata[spfcm_pkg::CTRL_REQ_BIT]    = r.req;
          n.rdata[spfcm_pkg::CTRL_ACTIVE_BIT] = AMP_OUT.active;
          n.rdata[spfcm_pkg::CTRL_WDT_BIT]    = r.wdt;
          n.rdata[spfcm_pkg::CTRL_ERR_BIT]    = r.err_flag;
          n.rdata[spfcm_pkg::CTRL_CLKREQ_BIT] = r.clk_req;
        end
        spfcm_pkg::REG_FETCH_AXIS: n.rdata = {16'h0, r.axis};
        spfcm_pkg::REG_AXIS_USED:  n.rdata = r.used;
        spfcm_pkg::REG_PARAM_SEL:
          n.rdata = {{(32-spfcm_pkg::RAM_AW){1'b0}}, r.sel};
        spfcm_pkg::REG_PARAM_DATA: n.rdata = {16'h0, mem_rdata};
        spfcm_pkg::REG_CLOCK_DATA: n.rdata = r.clk_data;
        spfcm_pkg::REG_ERR_CODE:   n.rdata = {16'h0, r.err_code};
        spfcm_pkg::REG_ERR_STAMP:  n.rdata = r.err_stamp;
        default:                   n.rdata = 32'h0;
      endcase
    end
    if (wr_en)
    begin
      case (adr)
        spfcm_pkg::REG_CTRL:
        begin
          if (WB_SEL_I[0])
          begin
            // Only software moves the request flag
            n.req     = WB_DAT_I[spfcm_pkg::CTRL_REQ_BIT];
            n.clk_req = WB_DAT_I[spfcm_pkg::CTRL_CLKREQ_BIT];
            if (WB_DAT_I[spfcm_pkg::CTRL_ERR_BIT])
              n.err_flag = 1'b0;
          end
        end
        spfcm_pkg::REG_FETCH_AXIS:
        begin
          wv     = spfcm_lanes({16'h0, r.axis}, WB_DAT_I, WB_SEL_I);
          n.axis = wv[15:0];
        end
        spfcm_pkg::REG_AXIS_USED:
          n.used = spfcm_lanes(r.used, WB_DAT_I, WB_SEL_I);
        spfcm_pkg::REG_PARAM_SEL:
        begin
          wv    = spfcm_lanes({{(32-spfcm_pkg::RAM_AW){1'b0}}, r.sel},
                              WB_DAT_I, WB_SEL_I);
          n.sel = wv[spfcm_pkg::RAM_AW-1:0];
        end
        spfcm_pkg::REG_CLOCK_DATA:
          n.clk_data = spfcm_lanes(r.clk_data, WB_DAT_I, WB_SEL_I);
        default:
          n.ack = n.ack;
      endcase
    end

    // Error capture; a new error beats a clear in the same cycle
    if (ERROR_EVENT)
    begin
      n.err_flag  = 1'b1;
      n.err_code  = ERROR_CODE;
      n.err_stamp = r.rtc;
    end

    // Fetch request edge against last cycle's flag
    n.req_prev = r.req;
    req_rise   = r.req & ~r.req_prev;
    axis_ok    = (r.axis != 16'h0) && (r.axis <= MAX_AXES);
    axis_idx   = spfcm_axis_cut(r.axis);

    case (r.fsm)
      spfcm_pkg::FS_IDLE:
      begin
        // Edges seen outside idle are simply dropped
        if (req_rise && axis_ok && r.used[axis_idx] &&
            r.pwr_lvl[axis_idx])
        begin
          n.fetch_axis = axis_idx;
          n.fsm        = spfcm_pkg::FS_START;
        end
        else if (r.auto_pend)
        begin
          n.fetch_axis = r.auto_axis;
          n.auto_pend  = 1'b0;
          n.fsm        = spfcm_pkg::FS_START;
        end
      end
      spfcm_pkg::FS_START:
      begin
        n.idx = '0;
        n.fsm = spfcm_pkg::FS_XFER;
      end
      spfcm_pkg::FS_XFER:
      begin
        if (AMP_IN.valid)
        begin
          mem_we = 1'b1;
          n.idx  = r.idx + 1'b1;
          if (AMP_IN.last)
            n.fsm = spfcm_pkg::FS_DONE;
        end
      end
      spfcm_pkg::FS_DONE:
        n.fsm = spfcm_pkg::FS_IDLE;
      default:
        n.fsm = spfcm_pkg::FS_IDLE;
    endcase

    // Pending auto update lives only in this flop, so reset loses it
    if (AMP_IN.changed)
    begin
      n.auto_pend = 1'b1;
      n.auto_axis = AMP_IN.changed_idx;
    end
  end

  function automatic logic [spfcm_pkg::AXIS_IDX_W-1:0] spfcm_axis_cut(
    input logic [15:0] v
  );
    logic [15:0] d;
    d = v - 16'h1;
    return d[spfcm_pkg::AXIS_IDX_W-1:0];
  endfunction : spfcm_axis_cut

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      r <= '0;
    else
      r <= n;
  end

  assign WB_ACK_O  = r.ack;
  assign WB_DAT_O  = r.rdata;
  assign WDT_ERROR = r.wdt;
  assign AMP_OUT   = '{start:    (r.fsm == spfcm_pkg::FS_START),
                       axis_idx: r.fetch_axis,
                       active:   (r.fsm == spfcm_pkg::FS_START) ||
                                 (r.fsm == spfcm_pkg::FS_XFER)};

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);

  property p_cur_cycle;
    mark_rise |=> (r.cur == $past(r.elapsed)) && (r.elapsed == 16'h0);
  endproperty
  a_cur_cycle: assert property (p_cur_cycle)
    else $error("current cycle not captured");
  property p_peak_ge;
    r.peak >= r.cur;
  endproperty
  a_peak_ge: assert property (p_peak_ge)
    else $error("peak below current cycle");
  property p_wdt;
    (r.elapsed > spfcm_pkg::WDT_LIMIT) |=> WDT_ERROR;
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog not raised");
  property p_edge_start;
    (r.fsm == spfcm_pkg::FS_IDLE) && req_rise && axis_ok &&
    r.used[axis_idx] && r.pwr_lvl[axis_idx]
    |=> AMP_OUT.start ##1 (AMP_OUT.active && !AMP_OUT.start);
  endproperty
  a_edge_start: assert property (p_edge_start)
    else $error("valid request edge did not start fetch");
  property p_level_quiet;
    (r.fsm == spfcm_pkg::FS_IDLE) && !req_rise && !r.auto_pend
    |=> !AMP_OUT.start;
  endproperty
  a_level_quiet: assert property (p_level_quiet)
    else $error("fetch started without an edge");
  property p_bad_axis;
    (r.fsm == spfcm_pkg::FS_IDLE) && req_rise && !r.auto_pend &&
    (!axis_ok || !r.used[axis_idx] || !r.pwr_lvl[axis_idx])
    |=> (r.fsm == spfcm_pkg::FS_IDLE);
  endproperty
  a_bad_axis: assert property (p_bad_axis)
    else $error("invalid axis started a fetch");
  property p_active_clear;
    (r.fsm == spfcm_pkg::FS_XFER) && AMP_IN.valid && AMP_IN.last
    |=> !AMP_OUT.active ##1 (r.fsm == spfcm_pkg::FS_IDLE);
  endproperty
  a_active_clear: assert property (p_active_clear)
    else $error("active flag not cleared after transfer");
  property p_busy_ignore;
    AMP_OUT.active |=> $stable(r.fetch_axis);
  endproperty
  a_busy_ignore: assert property (p_busy_ignore)
    else $error("request accepted while active");
  property p_req_kept;
    $past(r.req) && !$past(wr_en) |-> r.req;
  endproperty
  a_req_kept: assert property (p_req_kept)
    else $error("request flag cleared by hardware");
  property p_store;
    (r.fsm == spfcm_pkg::FS_XFER) && AMP_IN.valid
    |-> mem_we && (mem_waddr == {r.fetch_axis, r.idx});
  endproperty
  a_store: assert property (p_store)
    else $error("parameter word not stored");
  property p_auto;
    (r.fsm == spfcm_pkg::FS_IDLE) && r.auto_pend && !req_rise
    |=> AMP_OUT.start && (AMP_OUT.axis_idx == $past(r.auto_axis));
  endproperty
  a_auto: assert property (p_auto)
    else $error("automatic update not started");
  property p_error;
    ERROR_EVENT |=> r.err_flag && (r.err_code == $past(ERROR_CODE)) &&
                    (r.err_stamp == $past(r.rtc));
  endproperty
  a_error: assert property (p_error)
    else $error("error not recorded");

endmodule : spfcm_top
`default_nettype wire

// ===== sim/spfcm_amp_model.sv
// Servo amplifier model answering parameter fetch starts
`timescale 1ns/100ps
`default_nettype none
module spfcm_amp_model #(
  parameter int N_WORDS = 4
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire spfcm_pkg::spfcm_amp_out_type amp_out,
  input  wire logic [7:0]                   stall,
  input  wire logic                         chg,
  input  wire logic [4:0]                   chg_idx,
  output var  spfcm_pkg::spfcm_amp_in_type  amp_in
);
  logic       busy;
  logic [7:0] wait_cnt;
  logic [7:0] word;
  logic [4:0] axis;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      amp_in <= '0;
      busy <= 1'b0;
      wait_cnt <= 8'h00;
      word <= 8'h00;
      axis <= 5'h00;
    end
    else
    begin
      amp_in.changed <= chg;
      amp_in.changed_idx <= chg_idx;
      amp_in.valid <= 1'b0;
      amp_in.last <= 1'b0;
      // Released data toggles so a stale word never looks valid
      amp_in.data <= ~amp_in.data;
      if (amp_out.start)
      begin
        busy <= 1'b1;
        wait_cnt <= stall;
        word <= 8'h00;
        axis <= amp_out.axis_idx;
      end
      else if (busy && wait_cnt != 8'h00)
        wait_cnt <= wait_cnt - 8'h01;
      else if (busy)
      begin
        amp_in.valid <= 1'b1;
        amp_in.data <= {3'h5, axis, word};
        amp_in.last <= (word == 8'(N_WORDS - 1));
        word <= word + 8'h01;
        if (word == 8'(N_WORDS - 1))
          busy <= 1'b0;
      end
    end
  end
endmodule : spfcm_amp_model
`default_nettype wire

// ===== sim/spfcm_tb_top.sv
// Self-checking bench for the cycle monitor and parameter fetch block
`timescale 1ns/100ps
`default_nettype none
module spfcm_tb_top;
  localparam int T = 10;
  typedef struct packed {
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [31:0] exp;
  } spfcm_row_type;

  logic                         ref_clk = 1'b0;
  logic                         sys_rst = 1'b1;
  logic                         cyc = 1'b0;
  logic                         stb = 1'b0;
  logic                         we = 1'b0;
  logic [7:0]                   adr = 8'h00;
  logic [3:0]                   sel = 4'hF;
  logic [31:0]                  dat_w = 32'h0000_0000;
  logic [31:0]                  dat_r;
  logic                         ack;
  logic                         mark = 1'b0;
  logic [31:0]                  pwr = 32'h0000_0000;
  spfcm_pkg::spfcm_amp_in_type  amp_in;
  spfcm_pkg::spfcm_amp_out_type amp_out;
  logic                         err_ev = 1'b0;
  logic [15:0]                  err_code = 16'h0000;
  logic                         wdt;
  logic [7:0]                   stall = 8'h00;
  logic                         chg = 1'b0;
  logic [4:0]                   chg_idx = 5'h00;
  logic [31:0]                  q;
  int                           error_cnt = 0;
  int                           checks = 0;
  int                           starts = 0;
  int                           now = 0;
  int                           last_rise = 0;
  int                           s0;
  spfcm_row_type rows [10] = '{
    '{8'h00, 32'h0000_FFFF, 32'h0000_0000},
    '{8'h04, 32'h0000_FFFF, 32'h0000_0000},
    '{8'h08, 32'h0000_0000, 32'h0000_0000},
    '{8'h0C, 32'h0000_ABCD, 32'h0000_ABCD},
    '{8'h10, 32'hA5A5_A5A5, 32'hA5A5_A5A5},
    '{8'h14, 32'h0000_07FF, 32'h0000_07FF},
    '{8'h1C, 32'h1234_5678, 32'h1234_5678},
    '{8'h20, 32'h0000_FFFF, 32'h0000_0000},
    '{8'h24, 32'h0000_FFFF, 32'h0000_0000},
    '{8'h30, 32'hFFFF_FFFF, 32'h0000_0000}};
  int ms_tab [3] = '{40, 20, 50};
  int pk_tab [3] = '{40, 40, 50};
  logic [15:0] bad_ax [4] = '{16'h0002, 16'h0004, 16'h0000, 16'h0021};

  spfcm_top #(
    .TICK_CYCLES  (T),
    .LARGE_VARIANT(1'b1)
  ) spfcm_top_i (
    .REF_CLK        (ref_clk),
    .SYS_RST        (sys_rst),
    .WB_CYC_I       (cyc),
    .WB_STB_I       (stb),
    .WB_WE_I        (we),
    .WB_ADR_I       (adr),
    .WB_SEL_I       (sel),
    .WB_DAT_I       (dat_w),
    .WB_DAT_O       (dat_r),
    .WB_ACK_O       (ack),
    .MAIN_CYCLE_MARK(mark),
    .AXIS_POWERED   (pwr),
    .AMP_IN         (amp_in),
    .AMP_OUT        (amp_out),
    .ERROR_EVENT    (err_ev),
    .ERROR_CODE     (err_code),
    .WDT_ERROR      (wdt)
  );

  spfcm_amp_model #(
    .N_WORDS(4)
  ) spfcm_amp_model_i (
    .clk    (ref_clk),
    .rst    (sys_rst),
    .amp_out(amp_out),
    .stall  (stall),
    .chg    (chg),
    .chg_idx(chg_idx),
    .amp_in (amp_in)
  );

  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) now <= now + 1;
  // Counted at the falling edge, where the pulse has settled
  always @(negedge ref_clk) if (amp_out.start === 1'b1) starts++;

  function automatic logic [31:0] pw(input logic [4:0] ax,
                                     input logic [7:0] w);
    return {16'h0000, 3'h5, ax, w};
  endfunction : pw

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic wait_until(input int c);
    while (now < c) @(posedge ref_clk);
  endtask : wait_until

  // Request held up to the edge that samples ack; read data taken there
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    r = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50)
      chk("wb_ack", 32'h1, 32'h0);
    @(posedge ref_clk);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr

  task automatic mark_at(input int ms);
    wait_until(last_rise + ms * T + 5);
    mark <= 1'b1;
    last_rise = now;
    tick(3);
    mark <= 1'b0;
  endtask : mark_at

  task automatic wait_start(input logic [4:0] ax);
    int n;
    n = 0;
    while (amp_out.start !== 1'b1 && n < 300)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("fetch_axis", 32'(ax), 32'(amp_out.axis_idx));
    chk("active_at_start", 32'h1, 32'(amp_out.active));
    @(posedge ref_clk);
  endtask : wait_start

  task automatic wait_idle;
    int n;
    n = 0;
    while (amp_out.active !== 1'b0 && n < 300)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("active_cleared", 32'h0, 32'(amp_out.active));
    @(posedge ref_clk);
  endtask : wait_idle

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    tick(5);
    sys_rst <= 1'b0;
    tick(1);
    foreach (rows[i])
    begin
      wb(1'b0, rows[i].adr, 32'h0, q);
      chk("reset_value", 32'h0, q);
      wr(rows[i].adr, rows[i].wdat);
      wb(1'b0, rows[i].adr, 32'h0, q);
      chk("readback", rows[i].exp, q);
    end
    mark_at(1);
    foreach (ms_tab[i])
    begin
      mark_at(ms_tab[i]);
      tick(8);
      wb(1'b0, 8'h00, 32'h0, q);
      chk("current_cycle_time", 32'(ms_tab[i]), q);
      wb(1'b0, 8'h04, 32'h0, q);
      chk("peak_cycle_time", 32'(pk_tab[i]), q);
    end
    wait_until(last_rise + 1595 * T);
    @(negedge ref_clk);
    chk("wdt_early", 32'h0, 32'(wdt));
    wait_until(last_rise + 1605 * T);
    @(negedge ref_clk);
    chk("wdt_late", 32'h1, 32'(wdt));
    @(posedge ref_clk);
    pwr <= 32'h0000_0056;
    wr(8'h10, 32'h0000_005C);
    wr(8'h0C, 32'h0000_0003);
    s0 = starts;
    wr(8'h08, 32'h0000_0001);
    wait_start(5'h02);
    wait_idle();
    for (int w = 0; w < 4; w++)
    begin
      wr(8'h14, {21'h0, 5'h02, 6'(w)});
      wb(1'b0, 8'h18, 32'h0, q);
      chk("param_word", pw(5'h02, 8'(w)), q);
    end
    wb(1'b0, 8'h08, 32'h0, q);
    chk("ctrl_req_active", 32'h1, 32'(q[1:0]));
    tick(20);
    chk("held_request", 32'(s0 + 1), 32'(starts));
    wr(8'h08, 32'h0000_0000);
    wr(8'h08, 32'h0000_0001);
    wait_start(5'h02);
    wait_idle();
    wr(8'h08, 32'h0000_0000);
    wr(8'h0C, 32'h0000_0005);
    wr(8'h08, 32'h0000_0001);
    wait_start(5'h04);
    wait_idle();
    stall <= 8'h28;
    wr(8'h08, 32'h0000_0000);
    s0 = starts;
    wr(8'h08, 32'h0000_0001);
    wait_start(5'h04);
    wb(1'b0, 8'h08, 32'h0, q);
    chk("active_flag", 32'h1, 32'(q[1]));
    wr(8'h08, 32'h0000_0000);
    wr(8'h08, 32'h0000_0001);
    wait_idle();
    tick(10);
    chk("edge_while_active", 32'(s0 + 1), 32'(starts));
    stall <= 8'h00;
    foreach (bad_ax[i])
    begin
      wr(8'h08, 32'h0000_0000);
      wr(8'h0C, 32'(bad_ax[i]));
      wr(8'h08, 32'h0000_0001);
      tick(10);
      chk("no_fetch", 32'(s0 + 1), 32'(starts));
    end
    chg <= 1'b1;
    chg_idx <= 5'h06;
    tick(1);
    chg <= 1'b0;
    wait_start(5'h06);
    wait_idle();
    wr(8'h14, {21'h0, 5'h06, 6'h00});
    wb(1'b0, 8'h18, 32'h0, q);
    chk("auto_param_word", pw(5'h06, 8'h00), q);
    wr(8'h1C, 32'h0000_0007);
    wr(8'h08, 32'h0000_0010);
    err_code <= 16'h0BAD;
    err_ev <= 1'b1;
    tick(1);
    err_ev <= 1'b0;
    tick(2);
    wb(1'b0, 8'h20, 32'h0, q);
    chk("error_code", 32'h0000_0BAD, q);
    wb(1'b0, 8'h24, 32'h0, q);
    chk("error_stamp", 32'h0000_0007, q);
    wb(1'b0, 8'h08, 32'h0, q);
    chk("error_flag", 32'h1, 32'(q[3]));
    wr(8'h08, 32'h0000_0018);
    wb(1'b0, 8'h08, 32'h0, q);
    chk("error_flag_clear", 32'h0, 32'(q[3]));
    sys_rst <= 1'b1;
    tick(2);
    @(negedge ref_clk);
    chk("wdt_after_reset", 32'h0, 32'(wdt));
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    tick(1);
    wb(1'b0, 8'h04, 32'h0, q);
    chk("peak_after_reset", 32'h0, q);
    wb(1'b0, 8'h00, 32'h0, q);
    chk("cur_after_reset", 32'h0, q);
    wb(1'b0, 8'h08, 32'h0, q);
    chk("ctrl_after_reset", 32'h0, q);
    wrap_up();
  end

  initial
  begin
    repeat (60000) @(posedge ref_clk);
    error_cnt++;
    $display("ERROR watchdog expected finish seen timeout");
    wrap_up();
  end
endmodule : spfcm_tb_top
`default_nettype wire
